// ### rtl/wdt_top.v
// Watchdog with timed unlock, interrupt/reset modes and reset cause flags
`timescale 1ns/1ps
`include "wdt_regs.vh"

// Contract
// RULE1: Scan-chain reset sets its cause flag
// RULE2: Watchdog reset sets its cause flag
// RULE3: Brown-out reset sets its cause flag
// RULE4: External reset sets its cause flag
// RULE5: Power-on flag cleared only by software
// RULE6: Time-out in interrupt mode sets flag
// RULE7: Flag cleared on vector or write one
// RULE8: Interrupt needs flag, enable, global enable
// RULE9: Combined mode: vector drops enable and flag
// RULE10: Unserviced flag plus time-out gives reset
// RULE11: Enable bits select the four modes
// RULE12: Programmed fuse forces reset mode
// RULE13: Change enable self-clears after four cycles
// RULE14: Protected changes only while change enabled
// RULE15: Watchdog cause flag forces reset enable
// RULE16: Period is 2048 ticks shifted by code
// RULE17: Software restarts counter before period change
// RULE18: Init software clears cause flag, enable
// RULE19: Counter advances on oscillator ticks
// RULE20: Restart instruction zeroes the counter
// RULE21: Unlock write then change within four
// RULE22: Reset request lasts one clock cycle
// RULE23: Cross-domain signals synchronised
// RULE24: Reserved period codes act as longest
module wdt_top #(
	parameter        AW         = 12,
	parameter        CW         = 21,
	parameter [20:0] BASE_TICKS = `WDT_BASE_TICKS
) (
	input  wire          CLK_I,
	input  wire          RST_I,
	input  wire          PSEL_I,
	input  wire          PENABLE_I,
	input  wire          PWRITE_I,
	input  wire [AW-1:0] PADDR_I,
	input  wire [31:0]   PWDATA_I,
	input  wire [3:0]    PSTRB_I,
	output reg  [31:0]   PRDATA_O,
	output reg           PREADY_O,
	output reg           PSLVERR_O,
	input  wire          OSC_CLK_I,
	input  wire          FUSE_UNPROG_I,
	input  wire          EXT_RST_I,
	input  wire          BOR_RST_I,
	input  wire          SCAN_RST_I,
	input  wire          RESTART_I,
	input  wire          IRQ_ACK_I,
	input  wire          GIE_I,
	output reg           IRQ_O,
	output reg           SYS_RST_REQ_O
);

	// ----------------------------------------------------------------
	// Modes
	// ----------------------------------------------------------------
	localparam [1:0] MODE_STOP  = 2'b00;
	localparam [1:0] MODE_IRQ   = 2'b01;
	localparam [1:0] MODE_RST   = 2'b10;
	localparam [1:0] MODE_BOTH  = 2'b11;

	// ----------------------------------------------------------------
	// Period decode
	// ----------------------------------------------------------------
	function [CW-1:0] period_limit;
		input [3:0] code;
		reg   [3:0] c;
		begin
			c = (code > `WDT_MAX_CODE) ? `WDT_MAX_CODE : code; // RULE24
			period_limit = BASE_TICKS[CW-1:0] << c; // RULE16
		end
	endfunction

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	wire [4:0] sync_q;
	reg        osc_prev_r;
	wire       osc_s;
	wire       fuse_unprog_s;
	wire       ext_s;
	wire       bor_s;
	wire       scan_s;
	wire       osc_tick;

	wdt_sync #(
		.W (5)
	) u_sync (
		.clk_i (CLK_I),
		.rst_i (RST_I),
		.d_i   ({OSC_CLK_I, FUSE_UNPROG_I, EXT_RST_I, BOR_RST_I, SCAN_RST_I}),
		.q_o   (sync_q)
	);

	assign osc_s         = sync_q[4]; // RULE23
	assign fuse_unprog_s = sync_q[3];
	assign ext_s         = sync_q[2];
	assign bor_s         = sync_q[1];
	assign scan_s        = sync_q[0];

	always @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			osc_prev_r <= 1'b0;
		end else begin
			osc_prev_r <= osc_s;
		end
	end

	assign osc_tick = osc_s & ~osc_prev_r; // RULE19

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	reg        if_r;
	reg        ie_r;
	reg        ce_r;
	reg        re_r;
	reg [3:0]  per_r;
	reg [2:0]  ce_cnt_r;
	reg        scanrf_r;
	reg        wdog_cause_r;
	reg        bo_cause_r;
	reg        ext_cause_r;
	reg        po_cause_r;
	reg        pready_r;
	reg        if_nxt;
	reg        ie_nxt;
	reg        fire_irq;
	reg        fire_rst;

	wire       acc;
	wire       hit_ctrl;
	wire       hit_cause;
	wire       wr;
	wire       wr_ctrl;
	wire       wr_cause;
	wire [7:0] wd;
	wire       re_eff;
	wire       ie_eff;
	wire [1:0] mode;
	wire       timeout;
	wire [7:0] ctrl_rd;
	wire [7:0] cause_rd;

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	assign acc       = PSEL_I & PENABLE_I;
	assign hit_ctrl  = (PADDR_I == `WDT_CTRL_OFS);
	assign hit_cause = (PADDR_I == `WDT_CAUSE_OFS);
	assign wr        = acc & pready_r & PWRITE_I & PSTRB_I[0];
	assign wr_ctrl   = wr & hit_ctrl;
	assign wr_cause  = wr & hit_cause;
	assign wd        = PWDATA_I[7:0];

	// ----------------------------------------------------------------
	// Effective mode
	// ----------------------------------------------------------------
	assign re_eff = re_r | wdog_cause_r | ~fuse_unprog_s; // RULE15 RULE12
	assign ie_eff = ie_r & fuse_unprog_s; // RULE12
	assign mode   = {re_eff, ie_eff}; // RULE11

	wdt_counter #(
		.CW (CW)
	) u_counter (
		.clk_i     (CLK_I),
		.rst_i     (RST_I),
		.tick_i    (osc_tick),
		.restart_i (RESTART_I),
		.run_i     (mode != MODE_STOP),
		.limit_i   (period_limit(per_r)),
		.timeout_o (timeout)
	);

	// ----------------------------------------------------------------
	// Time-out action
	// ----------------------------------------------------------------
	always @* begin
		fire_irq = 1'b0;
		fire_rst = 1'b0;
		if (timeout) begin
			case (mode)
				MODE_STOP: begin
					fire_irq = 1'b0;
				end
				MODE_IRQ: begin
					fire_irq = 1'b1; // RULE6
				end
				MODE_RST: begin
					fire_rst = 1'b1;
				end
				MODE_BOTH: begin
					if (if_r) begin
						fire_rst = 1'b1; // RULE10
					end else begin
						fire_irq = 1'b1; // RULE9
					end
				end
				default: begin
					fire_rst = 1'b1;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Interrupt flag and enable
	// ----------------------------------------------------------------
	always @* begin
		if_nxt = if_r;
		ie_nxt = ie_r;
		if (wr_ctrl) begin
			ie_nxt = wd[`WDT_IE_BIT];
			if (wd[`WDT_IF_BIT]) begin
				if_nxt = 1'b0; // RULE7
			end
		end
		if (IRQ_ACK_I && if_r) begin
			if_nxt = 1'b0; // RULE7
			if (re_eff) begin
				ie_nxt = 1'b0; // RULE9
			end
		end
		if (fire_irq) begin
			if_nxt = 1'b1; // RULE6
		end
	end

	always @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			if_r  <= 1'b0;
			ie_r  <= 1'b0;
			IRQ_O <= 1'b0;
		end else begin
			if_r  <= if_nxt;
			ie_r  <= ie_nxt;
			IRQ_O <= if_nxt & ie_nxt & fuse_unprog_s & GIE_I; // RULE8
		end
	end

	// ----------------------------------------------------------------
	// Timed change window
	// ----------------------------------------------------------------
	always @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			ce_r     <= 1'b0;
			ce_cnt_r <= 3'h0;
		end else if (wr_ctrl && wd[`WDT_CE_BIT]) begin
			ce_r     <= 1'b1;
			ce_cnt_r <= `WDT_CE_CYCLES;
		end else if (ce_r) begin
			if (ce_cnt_r == 3'h1) begin
				ce_r <= 1'b0; // RULE13
			end
			ce_cnt_r <= ce_cnt_r - 3'h1;
		end
	end

	// ----------------------------------------------------------------
	// Reset enable and period
	// ----------------------------------------------------------------
	always @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			re_r  <= 1'b0;
			per_r <= 4'h0;
		end else if (wr_ctrl) begin
			if (wd[`WDT_RE_BIT]) begin
				re_r <= 1'b1;
			end else if (ce_r && !wdog_cause_r) begin
				re_r <= 1'b0; // RULE14 RULE15
			end
			if (ce_r) begin
				per_r <= {wd[`WDT_P3_BIT], wd[2:0]}; // RULE14
			end
		end
	end

	// ----------------------------------------------------------------
	// Reset request and cause flags
	// ----------------------------------------------------------------
	always @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			SYS_RST_REQ_O <= 1'b0;
		end else begin
			SYS_RST_REQ_O <= fire_rst; // RULE22
		end
	end

	always @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			scanrf_r     <= 1'b0;
			wdog_cause_r <= 1'b0;
			bo_cause_r   <= 1'b0;
			ext_cause_r  <= 1'b0;
			po_cause_r   <= 1'b1; // RULE5
		end else begin
			if (scan_s) begin
				scanrf_r <= 1'b1; // RULE1
			end else if (wr_cause && !wd[`WDT_SCANRF_BIT]) begin
				scanrf_r <= 1'b0;
			end
			if (fire_rst) begin
				wdog_cause_r <= 1'b1; // RULE2
			end else if (wr_cause && !wd[`WDT_WDCAUSE_BIT]) begin
				wdog_cause_r <= 1'b0;
			end
			if (bor_s) begin
				bo_cause_r <= 1'b1; // RULE3
			end else if (wr_cause && !wd[`WDT_BOCAUSE_BIT]) begin
				bo_cause_r <= 1'b0;
			end
			if (ext_s) begin
				ext_cause_r <= 1'b1; // RULE4
			end else if (wr_cause && !wd[`WDT_EXTCAUSE_BIT]) begin
				ext_cause_r <= 1'b0;
			end
			if (wr_cause && !wd[`WDT_POCAUSE_BIT]) begin
				po_cause_r <= 1'b0; // RULE5
			end
		end
	end

	// ----------------------------------------------------------------
	// APB answer
	// ----------------------------------------------------------------
	assign ctrl_rd  = {if_r, ie_eff, per_r[3], ce_r, re_eff, per_r[2:0]};
	assign cause_rd = {3'h0, scanrf_r, wdog_cause_r, bo_cause_r, ext_cause_r, po_cause_r};

	always @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			pready_r  <= 1'b0;
			PREADY_O  <= 1'b0;
			PSLVERR_O <= 1'b0;
			PRDATA_O  <= 32'h00000000;
		end else begin
			pready_r  <= acc & ~pready_r;
			PREADY_O  <= acc & ~pready_r;
			PSLVERR_O <= acc & ~pready_r & ~hit_ctrl & ~hit_cause;
			if (acc && !pready_r) begin
				if (PWRITE_I) begin
					PRDATA_O <= 32'h00000000;
				end else if (hit_ctrl) begin
					PRDATA_O <= {24'h000000, ctrl_rd};
				end else if (hit_cause) begin
					PRDATA_O <= {24'h000000, cause_rd};
				end else begin
					PRDATA_O <= 32'h00000000;
				end
			end else begin
				PRDATA_O <= 32'h00000000;
			end
		end
	end

endmodule // wdt_top

// ### rtl/wdt_regs.vh
// Register map, field positions, reset values and timing counts of the watchdog
`ifndef WDT_REGS_VH
`define WDT_REGS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define WDT_CTRL_OFS        12'h060
`define WDT_CAUSE_OFS       12'h064

// ----------------------------------------------------------------
// Control/status field positions
// ----------------------------------------------------------------
`define WDT_IF_BIT          7
`define WDT_IE_BIT          6
`define WDT_P3_BIT          5
`define WDT_CE_BIT          4
`define WDT_RE_BIT          3

// ----------------------------------------------------------------
// Reset cause field positions
// ----------------------------------------------------------------
`define WDT_SCANRF_BIT      4
`define WDT_WDCAUSE_BIT     3
`define WDT_BOCAUSE_BIT     2
`define WDT_EXTCAUSE_BIT    1
`define WDT_POCAUSE_BIT     0

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define WDT_CTRL_RST        8'h00
`define WDT_CAUSE_RST       8'h01
`define WDT_CE_CYCLES       3'h4
`define WDT_BASE_TICKS      21'h000800
`define WDT_MAX_CODE        4'h9

`endif

// ### rtl/wdt_sync.v
// Two-stage synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
module wdt_sync #(
	parameter W = 1
) (
	input  wire         clk_i,
	input  wire         rst_i,
	input  wire [W-1:0] d_i,
	output reg  [W-1:0] q_o
);

	reg [W-1:0] meta_r;

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta_r <= {W{1'b0}};
			q_o    <= {W{1'b0}};
		end else begin
			meta_r <= d_i;
			q_o    <= meta_r;
		end
	end

endmodule // wdt_sync

// ### rtl/wdt_counter.v
// Time-out counter advanced by synchronised oscillator ticks
`timescale 1ns/1ps
module wdt_counter #(
	parameter CW = 21
) (
	input  wire          clk_i,
	input  wire          rst_i,
	input  wire          tick_i,
	input  wire          restart_i,
	input  wire          run_i,
	input  wire [CW-1:0] limit_i,
	output reg           timeout_o
);

	reg  [CW-1:0] cnt_r;
	wire          hit;

	// A period shortened below the current count expires on the next tick
	assign hit = (cnt_r >= limit_i - {{(CW-1){1'b0}}, 1'b1});

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_r     <= {CW{1'b0}};
			timeout_o <= 1'b0;
		end else begin
			timeout_o <= 1'b0;
			if (restart_i || !run_i) begin
				cnt_r <= {CW{1'b0}}; // RULE20
			end else if (tick_i) begin // RULE19
				if (hit) begin
					cnt_r     <= {CW{1'b0}};
					timeout_o <= 1'b1;
				end else begin
					cnt_r <= cnt_r + {{(CW-1){1'b0}}, 1'b1};
				end
			end
		end
	end

endmodule // wdt_counter

// ### verification/wdt_checker.sv
// Port-level timing checks for the watchdog top
`timescale 1ns/1ps
module wdt_checker (
	input wire        CLK_I,
	input wire        RST_I,
	input wire        PSEL_I,
	input wire        PENABLE_I,
	input wire [31:0] PRDATA_O,
	input wire        PREADY_O,
	input wire        PSLVERR_O,
	input wire        GIE_I,
	input wire        IRQ_ACK_I,
	input wire        IRQ_O,
	input wire        SYS_RST_REQ_O
);
	// ----------------------------------------
	// Bus and timer properties
	// ----------------------------------------
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (RST_I);
	sequence s_setup;
		PSEL_I && !PENABLE_I;
	endsequence
	sequence s_access;
		PSEL_I && PENABLE_I;
	endsequence
	a_ready_wait: assert property (s_setup ##1 s_access |-> !PREADY_O ##1 PREADY_O)
		else $error("ready not in second access cycle");
	a_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
		else $error("ready longer than one cycle");
	a_ready_cause: assert property (PREADY_O |-> $past(PSEL_I) && $past(PENABLE_I))
		else $error("ready without access");
	a_err_ready: assert property (PSLVERR_O |-> PREADY_O)
		else $error("error without ready");
	a_rdata_idle: assert property (!PREADY_O |-> PRDATA_O == 32'h0)
		else $error("read data outside ready");
	a_rdata_upper: assert property (PREADY_O |-> PRDATA_O[31:8] == 24'h0)
		else $error("upper read data not zero");
	a_rst_pulse: assert property ($rose(SYS_RST_REQ_O) |=> !SYS_RST_REQ_O [*8])
		else $error("reset request not one cycle");
	a_irq_gie: assert property (IRQ_O |-> $past(GIE_I))
		else $error("interrupt without global enable");
	a_ack_drop: assert property ($rose(IRQ_ACK_I) && IRQ_O |-> ##2 !IRQ_O)
		else $error("interrupt kept after vector");
endmodule // wdt_checker

bind wdt_top wdt_checker chk (.CLK_I(CLK_I), .RST_I(RST_I), .PSEL_I(PSEL_I),
	.PENABLE_I(PENABLE_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
	.PSLVERR_O(PSLVERR_O), .GIE_I(GIE_I), .IRQ_ACK_I(IRQ_ACK_I), .IRQ_O(IRQ_O),
	.SYS_RST_REQ_O(SYS_RST_REQ_O));

// ### verification/wdt_core_model.sv
// Oscillator and interrupt-vectoring core model
`timescale 1ns/1ps
module wdt_core_model (
	input  wire clk_i,
	input  wire rst_i,
	input  wire irq_i,
	input  wire ack_en_i,
	output reg  osc_o,
	output reg  ack_o
);
	reg [1:0] cnt_r;
	reg       ack_d_r;
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_r <= 2'h0;
			osc_o <= 1'h0;
			ack_o <= 1'h0;
			ack_d_r <= 1'h0;
		end else begin
			cnt_r <= cnt_r + 2'h1;
			// Free-running slow oscillator, eight system cycles a period
			if (cnt_r == 2'h3)
				osc_o <= ~osc_o;
			// One-cycle vector per request, then two idle cycles before the next
			ack_o <= irq_i & ack_en_i & ~ack_o & ~ack_d_r;
			ack_d_r <= ack_o;
		end
	end
endmodule // wdt_core_model

// ### verification/wdt_top_tb.sv
// Self-checking bench for the watchdog top
`timescale 1ns/1ps
`include "wdt_regs.vh"
module wdt_top_tb;
	reg         CLK_I = 1'h0;
	reg         RST_I = 1'h1;
	reg         PSEL_I = 1'h0;
	reg         PENABLE_I = 1'h0;
	reg         PWRITE_I = 1'h0;
	reg  [11:0] PADDR_I = 12'h000;
	reg  [31:0] PWDATA_I = 32'h0;
	reg  [3:0]  PSTRB_I = 4'hF;
	reg         FUSE_UNPROG_I = 1'h1;
	reg  [2:0]  src = 3'h0;
	reg         RESTART_I = 1'h0;
	reg         GIE_I = 1'h0;
	reg         ack_en = 1'h0;
	wire [31:0] PRDATA_O;
	wire        PREADY_O;
	wire        PSLVERR_O;
	wire        IRQ_O;
	wire        SYS_RST_REQ_O;
	wire        osc;
	wire        ack;
	integer     bad_count = 0;
	integer     n_checks = 0;
	integer     nrst = 0;
	integer     n0;
	integer     c;
	integer     i;
	reg  [31:0] rd;
	reg         er;
	localparam  CT = `WDT_CTRL_OFS;
	localparam  CA = `WDT_CAUSE_OFS;

	always #50 CLK_I = ~CLK_I;
	always @(posedge CLK_I)
		if (SYS_RST_REQ_O === 1'h1)
			nrst = nrst + 1;

	wdt_top #(.BASE_TICKS(21'h000004)) uut (.CLK_I(CLK_I), .RST_I(RST_I), .PSEL_I(PSEL_I),
		.PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
		.PSTRB_I(PSTRB_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
		.OSC_CLK_I(osc), .FUSE_UNPROG_I(FUSE_UNPROG_I), .EXT_RST_I(src[0]),
		.BOR_RST_I(src[1]), .SCAN_RST_I(src[2]), .RESTART_I(RESTART_I),
		.IRQ_ACK_I(ack), .GIE_I(GIE_I), .IRQ_O(IRQ_O), .SYS_RST_REQ_O(SYS_RST_REQ_O));
	wdt_core_model core (.clk_i(CLK_I), .rst_i(RST_I), .irq_i(IRQ_O), .ack_en_i(ack_en),
		.osc_o(osc), .ack_o(ack));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task chk(input [31:0] g, input [31:0] e);
		begin
			n_checks = n_checks + 1;
			if (g !== e) begin
				bad_count = bad_count + 1;
				$display("mismatch at %0t: got %h want %h", $time, g, e);
			end
		end
	endtask
	// One transfer, or two back-to-back writes when two is set
	task apb(input w, input [11:0] a, input [7:0] d0, input [7:0] d1, input two);
		integer k;
		begin
			@(posedge CLK_I);
			for (k = 0; k <= two; k = k + 1) begin
				PSEL_I <= 1'h1;
				PENABLE_I <= 1'h0;
				PWRITE_I <= w;
				PADDR_I <= a;
				PWDATA_I <= {24'h0, k ? d1 : d0};
				@(posedge CLK_I);
				PENABLE_I <= 1'h1;
				@(posedge CLK_I);
				// Read ready and data as sampled by this rising edge
				while (PREADY_O !== 1'h1) @(posedge CLK_I);
				rd = PRDATA_O;
				er = PSLVERR_O;
			end
			PSEL_I <= 1'h0;
			PENABLE_I <= 1'h0;
		end
	endtask
	task rdchk(input [11:0] a, input [7:0] e);
		begin
			apb(1'h0, a, 8'h00, 8'h00, 1'h0);
			chk(rd, {24'h0, e});
		end
	endtask
	task wait_rst;
		begin
			c = 0;
			repeat (400) if (SYS_RST_REQ_O !== 1'h1) begin
				@(negedge CLK_I);
				c = c + 1;
			end
		end
	endtask
	task wait_irq(input v);
		begin
			repeat (200) if (IRQ_O !== v) @(negedge CLK_I);
			chk({31'h0, IRQ_O}, {31'h0, v});
		end
	endtask
	task restart;
		begin
			@(posedge CLK_I);
			RESTART_I <= 1'h1;
			@(posedge CLK_I);
			RESTART_I <= 1'h0;
		end
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_reset;
		begin
			rdchk(CT, 8'h00);
			rdchk(CA, 8'h01);
			apb(1'h0, 12'h068, 8'h00, 8'h00, 1'h0);
			chk({31'h0, er}, 32'h1);
			PSTRB_I <= 4'h0;
			apb(1'h1, CA, 8'h00, 8'h00, 1'h0);
			PSTRB_I <= 4'hF;
			rdchk(CA, 8'h01);
			apb(1'h1, CA, 8'hFE, 8'h00, 1'h0);
			rdchk(CA, 8'h00);
			$display("reset test done");
		end
	endtask
	task t_cause;
		begin
			for (i = 0; i < 3; i = i + 1) begin
				@(posedge CLK_I);
				src <= 3'h1 << i;
				repeat (4) @(posedge CLK_I);
				src <= 3'h0;
				repeat (3) @(posedge CLK_I);
				rdchk(CA, (i == 2) ? 8'h10 : (8'h02 << i));
				apb(1'h1, CA, 8'h00, 8'h00, 1'h0);
			end
			$display("cause test done");
		end
	endtask
	task t_irq;
		begin
			GIE_I <= 1'h1;
			restart;
			apb(1'h1, CT, 8'h18, 8'h41, 1'h1);
			wait_irq(1'h1);
			chk({31'h0, IRQ_O}, 32'h1);
			rdchk(CT, 8'hC1);
			GIE_I <= 1'h0;
			repeat (3) @(negedge CLK_I);
			chk({31'h0, IRQ_O}, 32'h0);
			apb(1'h1, CT, 8'hC1, 8'h00, 1'h0);
			rdchk(CT, 8'h41);
			GIE_I <= 1'h1;
			ack_en <= 1'h1;
			wait_irq(1'h1);
			wait_irq(1'h0);
			rdchk(CT, 8'h41);
			GIE_I <= 1'h0;
			apb(1'h1, CT, 8'h01, 8'h00, 1'h0);
			$display("interrupt test done");
		end
	endtask
	task t_rmode;
		begin
			apb(1'h1, CT, 8'h18, 8'h09, 1'h1);
			n0 = nrst;
			for (i = 0; i < 12; i = i + 1) begin
				repeat (15) @(posedge CLK_I);
				restart;
			end
			chk(nrst - n0, 0);
			wait_rst;
			chk({31'h0, c > 50 && c < 80}, 32'h1);
			rdchk(CA, 8'h08);
			apb(1'h1, CT, 8'h18, 8'h01, 1'h1);
			rdchk(CT, 8'h09);
			apb(1'h1, CA, 8'h00, 8'h00, 1'h0);
			apb(1'h1, CT, 8'h00, 8'h00, 1'h0);
			rdchk(CT, 8'h09);
			apb(1'h1, CT, 8'h18, 8'h01, 1'h1);
			rdchk(CT, 8'h01);
			apb(1'h1, CT, 8'h18, 8'h00, 1'h0);
			repeat (6) @(posedge CLK_I);
			apb(1'h1, CT, 8'h08, 8'h00, 1'h0);
			rdchk(CT, 8'h09);
			apb(1'h1, CT, 8'h18, 8'h00, 1'h1);
			rdchk(CT, 8'h00);
			$display("reset mode test done");
		end
	endtask
	task t_comb;
		begin
			apb(1'h1, CT, 8'h48, 8'h00, 1'h0);
			wait_rst;
			chk({31'h0, c > 50 && c < 90}, 32'h1);
			rdchk(CT, 8'hC8);
			apb(1'h1, CA, 8'h00, 8'h00, 1'h0);
			apb(1'h1, CT, 8'h80, 8'h00, 1'h0);
			apb(1'h1, CT, 8'h18, 8'h00, 1'h1);
			rdchk(CT, 8'h00);
			// Serviced first time-out drops enable and flag, leaving reset mode
			GIE_I <= 1'h1;
			ack_en <= 1'h1;
			apb(1'h1, CT, 8'h48, 8'h00, 1'h0);
			wait_irq(1'h1);
			wait_irq(1'h0);
			rdchk(CT, 8'h08);
			apb(1'h1, CT, 8'h18, 8'h00, 1'h1);
			GIE_I <= 1'h0;
			ack_en <= 1'h0;
			$display("combined test done");
		end
	endtask
	task t_fuse;
		begin
			FUSE_UNPROG_I <= 1'h0;
			repeat (4) @(posedge CLK_I);
			rdchk(CT, 8'h08);
			wait_rst;
			chk({31'h0, SYS_RST_REQ_O}, 32'h1);
			@(posedge CLK_I);
			FUSE_UNPROG_I <= 1'h1;
			$display("fuse test done");
		end
	endtask

	task report_and_stop;
		begin
			$display("checks %0d mismatches %0d", n_checks, bad_count);
			if (bad_count == 0 && n_checks > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask

	initial begin
		repeat (20) @(posedge CLK_I);
		RST_I <= 1'h0;
		t_reset;
		t_cause;
		t_irq;
		t_rmode;
		t_comb;
		t_fuse;
		report_and_stop;
	end
	initial begin
		repeat (8000) @(posedge CLK_I);
		bad_count = bad_count + 1;
		report_and_stop;
	end
endmodule // wdt_top_tb
